// >>> src/ads_defs.svh
// Timing constants, counts and widths for the dual-rail sleep sequencer.
// Assumes a 50 MHz system clock; included by its bare name.
`ifndef ADS_DEFS_SVH
`define ADS_DEFS_SVH

`define ADS_CLK_PERIOD_NS     20
`define ADS_SS_INTERVAL_US    8200
`define ADS_SS_CYCLES         ((`ADS_SS_INTERVAL_US * 1000) / `ADS_CLK_PERIOD_NS)
`define ADS_S0S3_DELAY_NS     60000
`define ADS_S0S3_CYCLES       (`ADS_S0S3_DELAY_NS / `ADS_CLK_PERIOD_NS)
`define ADS_DEGLITCH_NS       1000
`define ADS_DEGLITCH_CYCLES   (`ADS_DEGLITCH_NS / `ADS_CLK_PERIOD_NS)
`define ADS_WAKE_SS_PERIODS   3
`define ADS_MAX_RETRIES       3
`define ADS_CNT_W             24
`define ADS_RETRY_W           2

`endif

// >>> src/ads_pkg.sv
// Types for the dual-rail sleep sequencer.
// Stands alone; constants live in ads_defs.svh.
package ads_pkg;

    typedef enum logic [3:0] {
        ADS_ST_INIT   = 4'b0001,
        ADS_ST_ACTIVE = 4'b0010,
        ADS_ST_SUSP   = 4'b0100,
        ADS_ST_OFF    = 4'b1000
    } ads_state_t;

    typedef enum logic [4:0] {
        ADS_LDO_WAIT  = 5'b00001,
        ADS_LDO_RAMP  = 5'b00010,
        ADS_LDO_RUN   = 5'b00100,
        ADS_LDO_RETRY = 5'b01000,
        ADS_LDO_LATCH = 5'b10000
    } ads_ldo_t;

    typedef struct packed {
        logic susp;   // suspend-to-RAM request, active high
        logic off;    // soft-off request, active high
    } ads_req_t;

    typedef struct packed {
        logic       ldoEnable;
        logic       ldoRamping;
        logic [7:0] ldoRef;
        logic       ssSinkEnable;
        logic       standbyGateHigh;
        logic       nGateOe;
    } ads_out_t;

endpackage : ads_pkg

// >>> src/ads_deglitch.sv
// Deglitch filter for one level input.
// Input is synchronous to clk_sys; output changes only after a steady run.
`timescale 1ns/1ns
`default_nettype none
module ads_deglitch #(
    parameter int unsigned CYCLES = 50,
    parameter logic        INIT   = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic clkEn,
    input  wire logic din,
    output logic      dout
);
    import ads_pkg::*;

    logic [15:0] cnt_ff;
    logic        out_ff;
    wire  logic  differs = din != out_ff;
    wire  logic  done    = cnt_ff >= 16'(CYCLES - 1);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_ff <= 16'h0000;
            out_ff <= INIT;
        end else if (clkEn) begin
            // Any return to the held level restarts the run
            cnt_ff <= (differs && !done) ? cnt_ff + 16'h0001 : 16'h0000;
            if (differs && done) out_ff <= din;
        end
    end

    assign dout = out_ff;
endmodule : ads_deglitch
`default_nettype wire

// >>> src/ads_ss_timer.sv
// Soft-start interval timer: pulses once per interval while running.
// Runs on clk_sys; the interval length is a parameter for short sims.
`timescale 1ns/1ns
`default_nettype none
`include "ads_defs.svh"
module ads_ss_timer #(
    parameter int unsigned SS_CYCLES = `ADS_SS_CYCLES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic                  clkEn,
    input  wire logic                  run,
    output logic                       tick,
    output logic [`ADS_CNT_W-1:0]      count
);
    import ads_pkg::*;

    logic [`ADS_CNT_W-1:0] cnt_ff;
    wire  logic            last = cnt_ff == `ADS_CNT_W'(SS_CYCLES - 1);

    always_ff @(posedge clk_sys) begin
        if (srst || !run) cnt_ff <= '0;
        else if (clkEn) cnt_ff <= last ? '0 : cnt_ff + `ADS_CNT_W'(1);
    end

    assign tick  = run && clkEn && last;
    assign count = cnt_ff;
endmodule : ads_ss_timer
`default_nettype wire

// >>> src/ads_sequencer.sv
// Dual-rail ACPI sleep sequencer: state decode, soft-start, gate control,
// undervoltage retry. Inputs are synchronous to clk_sys; srst is the
// standby-supply power-on reset, held while that supply is low.
`timescale 1ns/1ns
`default_nettype none
`include "ads_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Both requests high is active, suspend low is suspend, both low is off.
// - Soft-off never moves straight into suspend-to-RAM.
// - Suspend drives the standby gate low so the P-switch conducts.
// - Keep-alive option keeps the P-switch on in soft-off; base turns it off.
// - Regulator holds the aux rail in sleep; N-switch feeds it when active.
// - Undervoltage counts only in sleep and after the first ramp ends.
// - Standby power-on reset holds the sequencer in reset.
// - Active state waits for the 12V rail good indication.
// - Active to suspend waits a fixed 60 us before switching outputs.
// - Active to soft-off switches outputs at once.
// - Both request inputs are deglitched.
// - One soft-start interval after reset before the first ramp starts.
// - Regulator reference ramps digitally over one soft-start interval.
// - Keep-alive sinks a soft current on the standby gate for one period.
// - After the ramp the standby gate is pulled fully low if enabled.
// - Three periods after 12V good: release N-gate, gate high, LDO standby.
// - N-gate is open drain, low outside active, sensed for 12V good.
// - Undervoltage disables the regulator and retries one interval later.
// - Fourth undervoltage after three retries latches off until reset.
module ads_sequencer #(
    parameter logic        KEEP_ALIVE = 1'b0,
    parameter int unsigned SS_CYCLES  = `ADS_SS_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       clkEn,
    input  wire logic       suspend_ram_request_n,
    input  wire logic       soft_off_request_n,
    input  wire logic       nGateSense,
    input  wire logic       auxUndervoltage,
    output logic            n_switch_gate_ctrl_o,
    output logic            n_switch_gate_ctrl_oe,
    output logic            standby_p_switch_gate,
    output logic            standbyGateSinkEn,
    output logic            ldoEnable,
    output logic [7:0]      ldoRef,
    output logic            ldoLatchedOff,
    output ads_pkg::ads_state_t powerState
);
    import ads_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Shared arithmetic
    // True once a run count has reached its terminal value
    function automatic logic ads_reached(input logic [15:0] cnt,
                                         input int unsigned limit);
        ads_reached = cnt >= 16'(limit - 1);
    endfunction : ads_reached

    ////////////////////////////////////////////////////////////////////////////
    // Input deglitch and decode
    logic     suspN;
    logic     offN;
    ads_req_t req;

    // Both filters share one length so a clean edge moves both together
    ads_deglitch #(.CYCLES(`ADS_DEGLITCH_CYCLES), .INIT(1'b1)) uDgSusp (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clkEn   (clkEn),
        .din     (suspend_ram_request_n),
        .dout    (suspN)
    );
    ads_deglitch #(.CYCLES(`ADS_DEGLITCH_CYCLES), .INIT(1'b1)) uDgOff (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clkEn   (clkEn),
        .din     (soft_off_request_n),
        .dout    (offN)
    );

    assign req.susp = !suspN;
    assign req.off  = !offN;

    wire logic reqActive  = suspN && offN;
    wire logic reqSusp    = !suspN && offN;
    wire logic reqOff     = !suspN && !offN;
    wire logic reqIllegal = suspN && !offN;
    wire logic railGood   = nGateSense;

    ////////////////////////////////////////////////////////////////////////////
    // Soft-start timebase
    logic                  ssRun;
    logic                  ssTick;
    logic [`ADS_CNT_W-1:0] ssCount;

    ads_ss_timer #(.SS_CYCLES(SS_CYCLES)) uSsTimer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clkEn   (clkEn),
        .run     (ssRun),
        .tick    (ssTick),
        .count   (ssCount)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sleep-state machine
    ads_state_t state_ff;
    ads_state_t nxt_state;
    logic [15:0] dly_ff;
    logic [1:0]  wake_ff;
    logic        wakeDone_ff;
    logic        railGood_ff;
    // Deglitchers start idle-high; decode waits until they have settled
    logic [15:0] settle_ff;

    wire logic dlyDone    = ads_reached(dly_ff, `ADS_S0S3_CYCLES);
    wire logic settleDone = ads_reached(settle_ff, `ADS_DEGLITCH_CYCLES + 2);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ADS_ST_INIT: begin
                // Before 12V is up an active request sits in a sleep state
                if (!settleDone) nxt_state = ADS_ST_INIT;
                else if (reqOff || (reqActive && !railGood_ff)) nxt_state = ADS_ST_OFF;
                else if (reqSusp) nxt_state = ADS_ST_SUSP;
                else if (reqActive) nxt_state = ADS_ST_ACTIVE;
            end
            ADS_ST_ACTIVE: begin
                if (reqOff) nxt_state = ADS_ST_OFF;
                else if (reqSusp && dlyDone) nxt_state = ADS_ST_SUSP;
            end
            ADS_ST_SUSP: begin
                if (reqOff) nxt_state = ADS_ST_OFF;
                else if (reqActive && wakeDone_ff) nxt_state = ADS_ST_ACTIVE;
            end
            ADS_ST_OFF: begin
                // Suspend request from off is ignored
                if (reqActive && wakeDone_ff) nxt_state = ADS_ST_ACTIVE;
            end
            default: nxt_state = ADS_ST_INIT;
        endcase
        // Forbidden pair overrides every transition above
        if (reqIllegal) nxt_state = state_ff;
    end

    wire logic isSleep   = state_ff != ADS_ST_ACTIVE;
    wire logic wakeCount = isSleep && reqActive && railGood_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff    <= ADS_ST_INIT;
            dly_ff      <= 16'h0000;
            settle_ff   <= 16'h0000;
            railGood_ff <= 1'b0;
        end else if (clkEn) begin
            state_ff    <= nxt_state;
            railGood_ff <= railGood;
            dly_ff      <= (state_ff == ADS_ST_ACTIVE && reqSusp) ? dly_ff + 16'h0001
                                                                 : 16'h0000;
            if (!settleDone) settle_ff <= settle_ff + 16'h0001;
        end
    end

    // Wake count restarts whenever the request or the rail drops
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wake_ff     <= 2'h0;
            wakeDone_ff <= 1'b0;
        end else if (clkEn) begin
            if (!wakeCount) begin
                wake_ff     <= 2'h0;
                wakeDone_ff <= 1'b0;
            end else if (ssTick && !wakeDone_ff) begin
                if (wake_ff == 2'(`ADS_WAKE_SS_PERIODS - 1)) wakeDone_ff <= 1'b1;
                else wake_ff <= wake_ff + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Regulator soft-start and undervoltage retry
    ads_ldo_t ldo_ff;
    ads_ldo_t nxt_ldo;
    logic [1:0] retry_ff;
    logic [1:0] nxt_retry;
    // Retry count never wraps: the fourth trip latches instead

    wire logic uvQualified = isSleep && ldo_ff == ADS_LDO_RUN && auxUndervoltage;

    always_comb begin
        nxt_ldo   = ldo_ff;
        nxt_retry = retry_ff;
        case (ldo_ff)
            ADS_LDO_WAIT: begin
                if (ssTick) nxt_ldo = ADS_LDO_RAMP;
            end
            ADS_LDO_RAMP: begin
                if (ssTick) nxt_ldo = ADS_LDO_RUN;
            end
            ADS_LDO_RUN: begin
                if (uvQualified) begin
                    if (retry_ff == 2'(`ADS_MAX_RETRIES)) nxt_ldo = ADS_LDO_LATCH;
                    else begin
                        nxt_ldo   = ADS_LDO_RETRY;
                        nxt_retry = retry_ff + 2'h1;
                    end
                end
            end
            ADS_LDO_RETRY: begin
                if (ssTick) nxt_ldo = ADS_LDO_RAMP;
            end
            ADS_LDO_LATCH: begin
                // Only srst leaves the latch
                nxt_ldo = ADS_LDO_LATCH;
            end
            default:       nxt_ldo = ADS_LDO_WAIT;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ldo_ff   <= ADS_LDO_WAIT;
            retry_ff <= 2'h0;
        end else if (clkEn) begin
            ldo_ff   <= nxt_ldo;
            retry_ff <= nxt_retry;
        end
    end

    // Timer runs while the LDO sequences or a wake is pending
    // Shared timer: a retry during a wake count may see a short first interval
    wire logic ldoTiming = ldo_ff inside {ADS_LDO_WAIT, ADS_LDO_RAMP, ADS_LDO_RETRY};
    assign ssRun = ldoTiming || wakeCount;

    ////////////////////////////////////////////////////////////////////////////
    // Output shaping
    // Registered so every port comes straight from a flop
    ads_out_t nxtOut;
    ads_out_t out_ff;

    wire logic inRamp   = ldo_ff == ADS_LDO_RAMP;
    wire logic ldoOn    = isSleep && (inRamp || ldo_ff == ADS_LDO_RUN);
    wire logic railOn   = state_ff == ADS_ST_SUSP
                       || (state_ff != ADS_ST_ACTIVE && KEEP_ALIVE);
    // Reference ramp follows timer progress; the count scaled by 256 over SS_CYCLES
    wire logic [7:0] rampRef = 8'((ssCount * 256) / SS_CYCLES);

    always_comb begin
        nxtOut.ldoEnable       = ldoOn;
        nxtOut.ldoRamping      = inRamp;
        nxtOut.ldoRef          = !ldoOn ? 8'h00 : inRamp ? rampRef : 8'hff;
        // Sink only while ramping; afterwards the gate is pulled hard
        nxtOut.ssSinkEnable    = railOn && KEEP_ALIVE && inRamp && isSleep;
        // Gate stays high until the ramp ends, then pulled fully low while railOn
        nxtOut.standbyGateHigh = !(railOn && ldo_ff == ADS_LDO_RUN);
        nxtOut.nGateOe         = isSleep;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_ff <= '{ldoEnable: 1'b0, ldoRamping: 1'b0, ldoRef: 8'h00,
                        ssSinkEnable: 1'b0, standbyGateHigh: 1'b1, nGateOe: 1'b1};
        end else if (clkEn) begin
            out_ff <= nxtOut;
        end
    end

    // Latch and state flags use the next-state decode, saving a cycle
    logic latch_ff;
    ads_state_t stateOut_ff;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            latch_ff    <= 1'b0;
            stateOut_ff <= ADS_ST_INIT;
        end else if (clkEn) begin
            latch_ff    <= nxt_ldo == ADS_LDO_LATCH;
            stateOut_ff <= nxt_state;
        end
    end

    // Open-drain data is held low; only the enable moves
    logic nGateData_ff;
    always_ff @(posedge clk_sys) begin
        if (srst) nGateData_ff <= 1'b0;
        else if (clkEn) nGateData_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port drive: every output straight from a register
    assign n_switch_gate_ctrl_o  = nGateData_ff;
    assign n_switch_gate_ctrl_oe = out_ff.nGateOe;
    assign standby_p_switch_gate = out_ff.standbyGateHigh;
    assign standbyGateSinkEn     = out_ff.ssSinkEnable;
    assign ldoEnable             = out_ff.ldoEnable;
    assign ldoRef                = out_ff.ldoRef;
    assign ldoLatchedOff         = latch_ff;
    assign powerState            = stateOut_ff;
endmodule : ads_sequencer
`default_nettype wire

// >>> verif/ads_sequencer_monitor.sv
// Checker for the dual-rail sleep sequencer, bound to its top module.
// Sees only the top ports; assumes clkEn stays high while checking.
`timescale 1ns/1ns
`default_nettype none
module ads_sequencer_monitor #(
    parameter logic KEEP_ALIVE = 1'b0
) (
    input wire logic                clk_sys,
    input wire logic                srst,
    input wire logic                clkEn,
    input wire logic                suspend_ram_request_n,
    input wire logic                soft_off_request_n,
    input wire logic                nGateSense,
    input wire logic                auxUndervoltage,
    input wire logic                n_switch_gate_ctrl_o,
    input wire logic                n_switch_gate_ctrl_oe,
    input wire logic                standby_p_switch_gate,
    input wire logic                standbyGateSinkEn,
    input wire logic                ldoEnable,
    input wire logic [7:0]          ldoRef,
    input wire logic                ldoLatchedOff,
    input wire ads_pkg::ads_state_t powerState
);
    import ads_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    AST_NGATE_DATA: assert property (n_switch_gate_ctrl_o == 1'b0)
        else $error("N-gate data not low");
    AST_NGATE_SLEEP: assert property (powerState != ADS_ST_ACTIVE |=> n_switch_gate_ctrl_oe)
        else $error("N-gate released outside active");
    AST_NO_OFF_SUSP: assert property (powerState == ADS_ST_OFF |=> powerState != ADS_ST_SUSP)
        else $error("Soft-off moved to suspend");
    AST_WAKE_12V: assert property (powerState != ADS_ST_ACTIVE && !nGateSense
        |=> powerState != ADS_ST_ACTIVE)
        else $error("Active entered without 12V good");
    AST_SUSP_GATE: assert property ((powerState == ADS_ST_SUSP && ldoRef == 8'hff) [*2]
        |-> !standby_p_switch_gate)
        else $error("P-switch off in suspend");
    AST_OFF_GATE: assert property ((powerState == ADS_ST_OFF && ldoRef == 8'hff) [*2]
        |-> standby_p_switch_gate == !KEEP_ALIVE)
        else $error("Soft-off P-switch wrong for option");
    AST_ACTIVE_OUT: assert property ((powerState == ADS_ST_ACTIVE) [*2]
        |-> !n_switch_gate_ctrl_oe && standby_p_switch_gate && !ldoEnable)
        else $error("Active outputs wrong");
    AST_LATCH_HOLD: assert property (ldoLatchedOff |=> ldoLatchedOff && !ldoEnable)
        else $error("Latch-off not held");
    AST_LATCH_CAUSE: assert property ($rose(ldoLatchedOff)
        |-> $past(auxUndervoltage) || $past(auxUndervoltage, 2))
        else $error("Latch-off without undervoltage");
    CV_ACTIVE: cover property (powerState == ADS_ST_ACTIVE);
    CV_SUSP: cover property (powerState == ADS_ST_SUSP);
    CV_LATCH: cover property ($rose(ldoLatchedOff));
endmodule : ads_sequencer_monitor
bind ads_sequencer ads_sequencer_monitor #(.KEEP_ALIVE(KEEP_ALIVE)) ads_sequencer_monitor_inst (
    .clk_sys(clk_sys), .srst(srst), .clkEn(clkEn),
    .suspend_ram_request_n(suspend_ram_request_n), .soft_off_request_n(soft_off_request_n),
    .nGateSense(nGateSense), .auxUndervoltage(auxUndervoltage),
    .n_switch_gate_ctrl_o(n_switch_gate_ctrl_o), .n_switch_gate_ctrl_oe(n_switch_gate_ctrl_oe),
    .standby_p_switch_gate(standby_p_switch_gate), .standbyGateSinkEn(standbyGateSinkEn),
    .ldoEnable(ldoEnable), .ldoRef(ldoRef), .ldoLatchedOff(ldoLatchedOff),
    .powerState(powerState));
`default_nettype wire

// >>> verif/ads_chipset_model.sv
// Chipset sleep outputs and supply monitors facing the sequencer.
// Command 0 active, 1 suspend, 2 soft-off, 3 forbidden pair on purpose.
`timescale 1ns/1ns
`default_nettype none
module ads_chipset_model (
    input wire logic [1:0] cmd,
    input wire logic       rail12Good,
    input wire logic       uvReq,
    output logic           chipset_suspend_ram_out_n,
    output logic           chipset_soft_off_out_n,
    output logic           nGateSense,
    output logic           auxUndervoltage
);
    // Forbidden pair only when the bench asks for it
    assign chipset_suspend_ram_out_n = (cmd == 2'h0) || (cmd == 2'h3);
    assign chipset_soft_off_out_n    = (cmd == 2'h0) || (cmd == 2'h1);
    // Monitors are plain levels; rail ramps are not modelled
    assign nGateSense      = rail12Good;
    assign auxUndervoltage = uvReq;
endmodule : ads_chipset_model
`default_nettype wire

// >>> verif/ads_sequencer_test.sv
// Self-checking bench for the dual-rail sleep sequencer.
// Short soft-start interval; inputs change on falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module ads_sequencer_test;
    import ads_pkg::*;
    localparam int unsigned SS = 100;
    logic clk_sys, srst, clkEn, rail12Good, uvReq;
    logic [1:0] cmd;
    wire logic susN, offN, nGateSense, auxUndervoltage;
    logic nOut, nOe, pGate, sinkEn, ldoEnable, ldoLatchedOff;
    logic [7:0] ldoRef;
    ads_state_t powerState;
    int error_cnt, tests_run;
    ads_chipset_model ads_chipset_model_inst (.cmd(cmd), .rail12Good(rail12Good),
        .uvReq(uvReq), .chipset_suspend_ram_out_n(susN), .chipset_soft_off_out_n(offN),
        .nGateSense(nGateSense), .auxUndervoltage(auxUndervoltage));
    ads_sequencer #(.KEEP_ALIVE(1'b0), .SS_CYCLES(SS)) ads_sequencer_inst (
        .clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .suspend_ram_request_n(susN),
        .soft_off_request_n(offN), .nGateSense(nGateSense),
        .auxUndervoltage(auxUndervoltage), .n_switch_gate_ctrl_o(nOut),
        .n_switch_gate_ctrl_oe(nOe), .standby_p_switch_gate(pGate),
        .standbyGateSinkEn(sinkEn), .ldoEnable(ldoEnable), .ldoRef(ldoRef),
        .ldoLatchedOff(ldoLatchedOff), .powerState(powerState));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    // Bounded wait; a hang ends the run at once
    task automatic wait_st(input ads_state_t st, input int lim);
        int i;
        i = 0;
        while (powerState !== st && i < lim) begin
            cyc(1);
            i++;
        end
        if (i >= lim) begin
            error_cnt++;
            $display("BAD %0t state wait ran out", $time);
            close_out();
        end
    endtask : wait_st
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_boot;
        cmd = 2'h2;
        cyc(10);
        srst = 1'b0;
        cyc(60);
        chk(8'(powerState), 8'(ADS_ST_OFF));
        chk(8'(ldoEnable), 8'h0);
        cyc(90);
        chk(8'(ldoEnable), 8'h1);
        chk(8'(ldoRef inside {8'h00, 8'hff}), 8'h0);
        cyc(100);
        chk(ldoRef, 8'hff);
        chk({nOe, pGate, sinkEn}, 8'h6);
        cmd = 2'h1;
        cyc(200);
        chk(8'(powerState), 8'(ADS_ST_OFF));
    endtask : s_boot
    task automatic s_wake;
        cmd = 2'h0;
        cyc(300);
        chk(8'(powerState), 8'(ADS_ST_OFF));
        rail12Good = 1'b1;
        cyc(190);
        chk(8'(powerState), 8'(ADS_ST_OFF));
        wait_st(ADS_ST_ACTIVE, 250);
        cyc(2);
        chk({nOe, pGate, ldoEnable}, 8'h2);
        chk(8'(nOut), 8'h0);
    endtask : s_wake
    task automatic s_act_off;
        cmd = 2'h2;
        wait_st(ADS_ST_OFF, 60);
        cyc(2);
        chk(8'(nOe), 8'h1);
        cyc(250);
        chk(8'(ldoEnable), 8'h1);
        cmd = 2'h0;
        wait_st(ADS_ST_ACTIVE, 400);
        cmd = 2'h1;
        cyc(20);
        cmd = 2'h0;
        cyc(100);
        chk(8'(powerState), 8'(ADS_ST_ACTIVE));
        repeat (5) begin
            uvReq = 1'b1;
            cyc(3);
            uvReq = 1'b0;
            cyc(10);
        end
        chk(8'(ldoLatchedOff), 8'h0);
    endtask : s_act_off
    task automatic s_act_susp;
        cmd = 2'h1;
        cyc(2900);
        chk(8'(powerState), 8'(ADS_ST_ACTIVE));
        wait_st(ADS_ST_SUSP, 250);
        cyc(2);
        chk({nOe, pGate}, 8'h2);
        cyc(250);
        chk(ldoRef, 8'hff);
        chk(8'(ldoEnable), 8'h1);
        cmd = 2'h3;
        cyc(150);
        chk(8'(powerState), 8'(ADS_ST_SUSP));
        cmd = 2'h1;
        cyc(60);
    endtask : s_act_susp
    task automatic s_uv;
        for (int i = 0; i < 4; i++) begin
            uvReq = 1'b1;
            cyc(3);
            uvReq = 1'b0;
            cyc(2);
            chk(8'(ldoEnable), 8'h0);
            chk(8'(ldoLatchedOff), 8'(i == 3));
            cyc(250);
            chk(8'(ldoEnable), 8'(i != 3));
        end
        srst = 1'b1;
        cyc(10);
        chk({4'h0, powerState}, {4'h0, ADS_ST_INIT});
        chk(8'(ldoLatchedOff), 8'h0);
        cmd = 2'h1;
        srst = 1'b0;
        cyc(60);
        chk(8'(powerState), 8'(ADS_ST_SUSP));
        cmd = 2'h2;
        cyc(60);
        chk(8'(powerState), 8'(ADS_ST_OFF));
    endtask : s_uv
    initial begin
        srst = 1'b1;
        clkEn = 1'b1;
        rail12Good = 1'b0;
        uvReq = 1'b0;
        cmd = 2'h2;
        error_cnt = 0;
        tests_run = 0;
        s_boot();
        s_wake();
        s_act_off();
        s_act_susp();
        s_uv();
        close_out();
    end
endmodule : ads_sequencer_test
`default_nettype wire
